// ==== ccms_mode_status.sv ====
// Counter/converter mode status register with access hold-off
`timescale 1ns/10ps
// What this block does
// - The single-cell flag in bit 3 is caught once at power-on and software can only read it.
// - The single-cell flag reads 1 when the auxiliary supply was valid at power-on, else 0.
// - Bit 2 shows the second converter mode, 0 for switching buck and 1 for linear regulation.
// - Bits 1 to 0 show the first converter mode as a read-only field that is zero after reset.
// - While software reads the register its contents stop updating so a read stays coherent.
// - During counter calibration each converter is forced to hold the mode it had at the start.
module ccms_mode_status
   import ccms_pkg::*;
(
   input  wire logic                                 CLK,
   input  wire logic                                 RESET_N,
   input  wire logic                                 AUX_SUPPLY_VALID,
   input  wire logic [ccms_pkg::CCMS_FIRST_MODE_W-1:0] FIRST_CONV_MODE_LIVE,
   input  wire logic                                 SECOND_CONV_MODE_LIVE,
   input  wire logic                                 CAL_ACTIVE,
   input  wire logic                                 REG_SELECT,
   input  wire logic [ccms_pkg::CCMS_ADDR_W-1:0]       REG_ADDR,
   input  wire logic                                 REG_WRITE,
   output logic [ccms_pkg::CCMS_DATA_W-1:0]            REG_RDATA,
   output logic                                      REG_HIT,
   output logic                                      UPDATE_HOLD,
   output logic                                      FIRST_CONV_LOCK,
   output logic [ccms_pkg::CCMS_FIRST_MODE_W-1:0]      FIRST_CONV_LOCK_MODE,
   output logic                                      SECOND_CONV_LOCK,
   output logic                                      SECOND_CONV_LOCK_MODE
);
   import ccms_pkg::*;

   ccms_access_t                  access_state;
   ccms_access_t                  next_access_state;
   logic                          sc_captured;
   logic                          next_sc_captured;
   logic                          single_cell_flag;
   logic                          next_single_cell_flag;
   logic [CCMS_DATA_W-1:0]        next_reg_rdata;
   logic [CCMS_DATA_W-1:0]        live_image;
   logic [CCMS_FIRST_MODE_W-1:0]  first_converter_mode;
   logic                          second_converter_mode;
   logic                          hold;
   logic                          addressed;

   ////////////////////////////////////////////////////////////////////////
   // Field packing and decode helpers
   function automatic logic [CCMS_DATA_W-1:0] pack_mode(input logic sc,
                                                      input logic second,
                                                      input logic [CCMS_FIRST_MODE_W-1:0] first);
      logic [CCMS_DATA_W-1:0] v;
      v = CCMS_MODE_RESET;
      v[CCMS_SC_BIT] = sc;
      v[CCMS_SECOND_BIT] = second;
      v[CCMS_FIRST_MSB:CCMS_FIRST_LSB] = first;
      return v;
   endfunction : pack_mode

   function automatic logic decode_hit(input logic                   sel,
                                       input logic [CCMS_ADDR_W-1:0] addr,
                                       input logic                   wr);
      logic hit_v;
      logic addr_v;
      addr_v = (addr == CCMS_MODE_OFFSET);
      hit_v  = sel && addr_v;
      if (wr) begin
         hit_v = 1'b0;
      end
      return hit_v;
   endfunction : decode_hit

   function automatic logic hold_needed(input logic         hit,
                                        input ccms_access_t state);
      logic hold_v;
      hold_v = hit;
      if (state == CCMS_ADDRESSED) begin
         hold_v = 1'b1;
      end
      return hold_v;
   endfunction : hold_needed

   function automatic logic supply_to_flag(input logic aux);
      logic flag_v;
      flag_v = CCMS_SC_ABSENT;
      if (aux) begin
         flag_v = CCMS_SC_PRESENT;
      end
      return flag_v;
   endfunction : supply_to_flag

   function automatic ccms_access_t after_addressed(input logic hit);
      ccms_access_t state_v;
      state_v = CCMS_RELEASE;
      if (hit) begin
         state_v = CCMS_ADDRESSED;
      end
      return state_v;
   endfunction : after_addressed

   function automatic ccms_access_t after_release(input logic hit);
      ccms_access_t state_v;
      state_v = CCMS_IDLE;
      if (hit) begin
         state_v = CCMS_ADDRESSED;
      end
      return state_v;
   endfunction : after_release

   ////////////////////////////////////////////////////////////////////////
   // Address decode; writes to a read-only register are ignored
   assign addressed = decode_hit(REG_SELECT, REG_ADDR, REG_WRITE);
   assign REG_HIT   = addressed;

   ////////////////////////////////////////////////////////////////////////
   // Access tracking for the update hold-off
   always_comb begin
      next_access_state = access_state;
      case (access_state)
         CCMS_IDLE: begin
            if (addressed) begin
               next_access_state = CCMS_ADDRESSED;
            end
         end
         CCMS_ADDRESSED: begin
            next_access_state = after_addressed(addressed);
         end
         CCMS_RELEASE: begin
            next_access_state = after_release(addressed);
         end
         default: begin
            next_access_state = CCMS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         access_state <= CCMS_IDLE;
      end else begin
         access_state <= next_access_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hold-off shared by the image and the trackers
   assign hold        = hold_needed(addressed, access_state);
   assign UPDATE_HOLD = hold;

   ////////////////////////////////////////////////////////////////////////
   // Power-on single-cell capture
   always_comb begin
      next_sc_captured      = 1'b1;
      next_single_cell_flag = single_cell_flag;
      if (!sc_captured) begin
         next_single_cell_flag = supply_to_flag(AUX_SUPPLY_VALID);
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         sc_captured      <= 1'b0;
         single_cell_flag <= CCMS_SC_ABSENT;
      end else begin
         sc_captured      <= next_sc_captured;
         single_cell_flag <= next_single_cell_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter mode trackers
   ccms_mode_track #(
      .W         (CCMS_FIRST_MODE_W),
      .RESET_VAL (CCMS_FIRST_RESET)
   ) u_first (
      .clk        (CLK),
      .reset_n    (RESET_N),
      .live_mode  (FIRST_CONV_MODE_LIVE),
      .cal_active (CAL_ACTIVE),
      .hold       (hold),
      .lock       (FIRST_CONV_LOCK),
      .lock_mode  (FIRST_CONV_LOCK_MODE),
      .shown_mode (first_converter_mode)
   );

   ccms_mode_track #(
      .W         (1),
      .RESET_VAL (CCMS_SECOND_BUCK)
   ) u_second (
      .clk        (CLK),
      .reset_n    (RESET_N),
      .live_mode  (SECOND_CONV_MODE_LIVE),
      .cal_active (CAL_ACTIVE),
      .hold       (hold),
      .lock       (SECOND_CONV_LOCK),
      .lock_mode  (SECOND_CONV_LOCK_MODE),
      .shown_mode (second_converter_mode)
   );

   ////////////////////////////////////////////////////////////////////////
   // Live image of the status fields
   always_comb begin
      live_image = pack_mode(single_cell_flag, second_converter_mode,
                             first_converter_mode);
   end

   ////////////////////////////////////////////////////////////////////////
   // Register image, frozen while addressed
   always_comb begin
      next_reg_rdata = REG_RDATA;
      if (!hold) begin
         next_reg_rdata = live_image;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         REG_RDATA <= CCMS_MODE_RESET;
      end else begin
         REG_RDATA <= next_reg_rdata;
      end
   end
endmodule : ccms_mode_status

// ==== ccms_mode_status_asserts.sv ====
// Checker for the mode status register block
`timescale 1ns/10ps
module ccms_mode_status_asserts (
   input wire logic       CLK,
   input wire logic       RESET_N,
   input wire logic       AUX_SUPPLY_VALID,
   input wire logic [1:0] FIRST_CONV_MODE_LIVE,
   input wire logic       SECOND_CONV_MODE_LIVE,
   input wire logic       CAL_ACTIVE,
   input wire logic       REG_SELECT,
   input wire logic [7:0] REG_ADDR,
   input wire logic       REG_WRITE,
   input wire logic [7:0] REG_RDATA,
   input wire logic       REG_HIT,
   input wire logic       UPDATE_HOLD,
   input wire logic       FIRST_CONV_LOCK,
   input wire logic [1:0] FIRST_CONV_LOCK_MODE,
   input wire logic       SECOND_CONV_LOCK,
   input wire logic       SECOND_CONV_LOCK_MODE
);
   logic first_edge;
   logic sc_exp;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK) begin
      first_edge <= !RESET_N;
      if (RESET_N && first_edge) begin
         sc_exp <= AUX_SUPPLY_VALID;
      end
   end
   ////////////////////////////////////////////////////////////////
   property p_hit; REG_HIT == (REG_SELECT && REG_ADDR == 8'h12 && !REG_WRITE); endproperty
   a_hit: assert property (p_hit) else $error("hit decode wrong");
   property p_freeze; $past(REG_HIT) |-> $stable(REG_RDATA); endproperty
   a_freeze: assert property (p_freeze) else $error("data moved in hold");
   property p_release; $fell(REG_HIT) |-> UPDATE_HOLD ##1 (!UPDATE_HOLD || REG_HIT); endproperty
   a_release: assert property (p_release) else $error("hold not released");
   property p_track;
      !REG_HIT && !$past(REG_HIT) && !$past(REG_HIT, 2) && $past(RESET_N, 2) |=>
         REG_RDATA == {4'h0, $past(sc_exp), $past(SECOND_CONV_MODE_LIVE, 2), $past(FIRST_CONV_MODE_LIVE, 2)};
   endproperty
   a_track: assert property (p_track) else $error("image not tracking");
   property p_sc_val; $past(RESET_N, 3) |-> REG_RDATA[3] == sc_exp; endproperty
   a_sc_val: assert property (p_sc_val) else $error("flag wrong");
   property p_sc_hold; $past(RESET_N, 3) |-> $stable(REG_RDATA[3]); endproperty
   a_sc_hold: assert property (p_sc_hold) else $error("flag changed");
   property p_lock; $past(RESET_N) |-> FIRST_CONV_LOCK == $past(CAL_ACTIVE) && SECOND_CONV_LOCK == FIRST_CONV_LOCK;
   endproperty
   a_lock: assert property (p_lock) else $error("lock wrong");
   property p_catch; $rose(CAL_ACTIVE) |=> {FIRST_CONV_LOCK_MODE, SECOND_CONV_LOCK_MODE} ==
      $past({FIRST_CONV_MODE_LIVE, SECOND_CONV_MODE_LIVE}); endproperty
   a_catch: assert property (p_catch) else $error("lock mode wrong");
   c_read: cover property ($rose(REG_HIT));
   c_cal: cover property ($rose(CAL_ACTIVE));
   c_write: cover property (REG_SELECT && REG_WRITE);
   c_back: cover property ($fell(REG_HIT) ##1 REG_HIT);
endmodule : ccms_mode_status_asserts
bind ccms_mode_status ccms_mode_status_asserts chk_u (.CLK(CLK), .RESET_N(RESET_N),
   .AUX_SUPPLY_VALID(AUX_SUPPLY_VALID), .FIRST_CONV_MODE_LIVE(FIRST_CONV_MODE_LIVE),
   .SECOND_CONV_MODE_LIVE(SECOND_CONV_MODE_LIVE), .CAL_ACTIVE(CAL_ACTIVE), .REG_SELECT(REG_SELECT),
   .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT),
   .UPDATE_HOLD(UPDATE_HOLD), .FIRST_CONV_LOCK(FIRST_CONV_LOCK), .FIRST_CONV_LOCK_MODE(FIRST_CONV_LOCK_MODE),
   .SECOND_CONV_LOCK(SECOND_CONV_LOCK), .SECOND_CONV_LOCK_MODE(SECOND_CONV_LOCK_MODE));

// ==== ccms_mode_track.sv ====
// Tracks one converter's mode with update hold and calibration lock
`timescale 1ns/10ps
module ccms_mode_track #(
   parameter int          W        = 2,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] live_mode,
   input  wire logic         cal_active,
   input  wire logic         hold,
   output logic              lock,
   output logic [W-1:0]      lock_mode,
   output logic [W-1:0]      shown_mode
);
   logic         next_lock;
   logic [W-1:0] next_lock_mode;
   logic [W-1:0] next_shown_mode;

   ////////////////////////////////////////////////////////////////////////
   // Next values
   always_comb begin
      next_lock       = cal_active;
      next_lock_mode  = lock_mode;
      next_shown_mode = shown_mode;
      if (cal_active && !lock) begin
         next_lock_mode = live_mode;
      end
      if (!hold) begin
         next_shown_mode = live_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lock       <= 1'b0;
         lock_mode  <= RESET_VAL;
         shown_mode <= RESET_VAL;
      end else begin
         lock       <= next_lock;
         lock_mode  <= next_lock_mode;
         shown_mode <= next_shown_mode;
      end
   end
endmodule : ccms_mode_track

// ==== ccms_pkg.sv ====
// Constants for the counter/converter mode status register block
package ccms_pkg;
   localparam int          CCMS_ADDR_W        = 8;
   localparam int          CCMS_DATA_W        = 8;
   localparam int          CCMS_FIRST_MODE_W  = 2;
   localparam logic [7:0]  CCMS_MODE_OFFSET   = 8'h12;
   localparam logic [7:0]  CCMS_MODE_RESET    = 8'h00;
   localparam int          CCMS_SC_BIT        = 3;
   localparam int          CCMS_SECOND_BIT    = 2;
   localparam int          CCMS_FIRST_MSB     = 1;
   localparam int          CCMS_FIRST_LSB     = 0;
   localparam logic [1:0]  CCMS_FIRST_RESET   = 2'h0;
   localparam logic        CCMS_SECOND_BUCK   = 1'b0;
   localparam logic        CCMS_SECOND_LINEAR = 1'b1;
   localparam logic        CCMS_SC_ABSENT     = 1'b0;
   localparam logic        CCMS_SC_PRESENT    = 1'b1;

   typedef enum logic [1:0] {
      CCMS_IDLE      = 2'b00,
      CCMS_ADDRESSED = 2'b01,
      CCMS_RELEASE   = 2'b11
   } ccms_access_t;
endpackage : ccms_pkg

// ==== test_ccms_mode_status.sv ====
// Self-checking bench for the mode status register block
`timescale 1ns/10ps
module test_ccms_mode_status;
   import ccms_pkg::*;
   logic       clk = 0, rst_n = 0, aux = 0, sec = 0, cal = 0, sel = 0, wr = 0, sc = 0;
   logic [1:0] fst = 0;
   logic [7:0] addr = 0;
   logic [7:0] rdata;
   logic       hit, f_lock, s_lock, s_lm, upd_hold;
   logic [1:0] f_lm;
   int         err_total = 0, checks_done = 0, i, k;
   integer     seed = 32'h87c8cc27;
   always #20 clk = ~clk;
   ccms_mode_status dut_u (.CLK(clk), .RESET_N(rst_n), .AUX_SUPPLY_VALID(aux), .FIRST_CONV_MODE_LIVE(fst),
      .SECOND_CONV_MODE_LIVE(sec), .CAL_ACTIVE(cal), .REG_SELECT(sel), .REG_ADDR(addr), .REG_WRITE(wr),
      .REG_RDATA(rdata), .REG_HIT(hit), .UPDATE_HOLD(upd_hold), .FIRST_CONV_LOCK(f_lock),
      .FIRST_CONV_LOCK_MODE(f_lm), .SECOND_CONV_LOCK(s_lock), .SECOND_CONV_LOCK_MODE(s_lm));
   ////////////////////////////////////////////////////////////////
   function logic [7:0] img(input logic [1:0] f, input logic b);
      return {4'h0, sc, b, f};
   endfunction : img
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task reset_run(input logic a);
      @(posedge clk);
      rst_n <= 0;
      aux <= a;
      sc = a;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("reset", CCMS_MODE_RESET, rdata);
      @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      aux <= ~a;
   endtask : reset_run
   task rd(input logic [1:0] f, input logic b, input int kind);
      @(posedge clk);
      fst <= f;
      sec <= b;
      repeat (2) @(posedge clk);
      sel <= 1;
      addr <= (kind == 1) ? 8'h13 : CCMS_MODE_OFFSET;
      wr <= (kind == 2);
      @(negedge clk);
      chk("hit", {7'h0, kind == 0}, {7'h0, hit});
      chk("rdata", img(f, b), rdata);
      @(posedge clk);
      fst <= ~f;
      sec <= ~b;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("held", (kind == 0) ? img(f, b) : img(~f, ~b), rdata);
      chk("hold", {7'h0, kind == 0}, {7'h0, upd_hold});
      @(posedge clk);
      sel <= 0;
      wr <= 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("resumed", img(~f, ~b), rdata);
      chk("released", 8'h00, {7'h0, upd_hold});
   endtask : rd
   task rd_again(input logic [1:0] f, input logic b);
      @(posedge clk);
      fst <= f;
      sec <= b;
      repeat (2) @(posedge clk);
      sel <= 1;
      addr <= CCMS_MODE_OFFSET;
      wr <= 0;
      @(posedge clk);
      sel <= 0;
      fst <= ~f;
      sec <= ~b;
      @(negedge clk);
      chk("gap hold", 8'h01, {7'h0, upd_hold});
      @(posedge clk);
      sel <= 1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("reheld", img(f, b), rdata);
      @(posedge clk);
      sel <= 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("reresumed", img(~f, ~b), rdata);
   endtask : rd_again
   task cal_run(input logic [1:0] f, input logic b);
      @(posedge clk);
      fst <= f;
      sec <= b;
      cal <= 1;
      @(posedge clk);
      fst <= ~f;
      sec <= ~b;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("lock", {3'h0, 2'b11, f, b}, {3'h0, f_lock, s_lock, f_lm, s_lm});
      @(posedge clk);
      cal <= 0;
      @(posedge clk);
      @(negedge clk);
      chk("unlock", 8'h00, {6'h0, f_lock, s_lock});
   endtask : cal_run
   task give_verdict;
      $display("Checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict;
   end
   initial begin
      for (i = 0; i < 2; i++) begin
         reset_run(i[0]);
         rd(2'h3, 1'b1, 0);
         for (k = 0; k < 12; k++) begin
            rd(2'($random(seed)), 1'($random(seed)), k % 3);
            cal_run(2'($random(seed)), 1'($random(seed)));
            rd_again(2'($random(seed)), 1'($random(seed)));
         end
      end
      give_verdict;
   end
endmodule : test_ccms_mode_status
